// file: core/lsfd_pkg.sv
// Package: constants and types for the low-side fault diagnostics block
package lsfd_pkg;
    localparam int NCH = 6;
    // Clock rate and documented times
    localparam longint CLK_HZ        = 50000000;
    localparam longint REFRESH_SHORT_MS = 10;
    localparam longint REFRESH_LONG_MS  = 40;
    localparam int REFRESH_SHORT_CYC =
        int'((REFRESH_SHORT_MS * CLK_HZ) / 1000);
    localparam int REFRESH_LONG_CYC  =
        int'((REFRESH_LONG_MS * CLK_HZ) / 1000);
    // Default blanking and filter lengths in cycles
    localparam int ON_BLANK_CYC_DEF  = 500;
    localparam int OFF_BLANK_CYC_DEF = 500;
    localparam int FILTER_CYC_DEF    = 100;
    localparam int TMR_W = 22;
    // Fault codes
    localparam logic [1:0] FC_NONE  = 2'h0;
    localparam logic [1:0] FC_OPEN  = 2'h1;
    localparam logic [1:0] FC_GND   = 2'h2;
    localparam logic [1:0] FC_SHORT = 2'h3;
    // Reset values
    localparam logic [5:0] MODE_RST = 6'h00;
    typedef enum logic [2:0] {
        LSFD_IDLE  = 3'b001,
        LSFD_BLANK = 3'b010,
        LSFD_FILT  = 3'b100
    } lsfd_tmr_t;
endpackage

// file: core/lsfd_refresh_if.sv
// Interface: shared refresh timer requests and taps
`timescale 1ns/1ps
interface lsfd_refresh_if;
    logic       start;
    logic       tap_short;
    logic       tap_long;
    logic       running;
    modport timer (input start, output tap_short, output tap_long,
                   output running);
    modport user  (output start, input tap_short, input tap_long,
                   input running);
endinterface

// file: core/lsfd_refresh_timer.sv
// Module: global refresh timer with two taps
`timescale 1ns/1ps
module lsfd_refresh_timer
    import lsfd_pkg::*;
#(
    parameter int SHORT_CYC = REFRESH_SHORT_CYC,
    parameter int LONG_CYC  = REFRESH_LONG_CYC
) (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    // Timer port
    lsfd_refresh_if.timer   rf
);
    logic [TMR_W-1:0] cnt_q, cnt_d;
    logic [TMR_W-1:0] sc_q, sc_d;
    logic             run_q, run_d;
    logic             ts_q, ts_d, tl_q, tl_d;

    always_comb begin
        cnt_d = cnt_q;
        sc_d  = sc_q;
        run_d = run_q;
        ts_d  = 1'b0;
        tl_d  = 1'b0;
        if (run_q) begin
            cnt_d = cnt_q + 1'b1;
            sc_d  = sc_q + 1'b1;
            // Short tap repeats every short period
            if (sc_q == TMR_W'(SHORT_CYC - 1)) begin
                ts_d = 1'b1;
                sc_d = '0;
            end
            if (cnt_q == TMR_W'(LONG_CYC - 1)) begin
                tl_d  = 1'b1;
                ts_d  = 1'b1;
                cnt_d = '0;
                sc_d  = '0;
                run_d = rf.start;
            end
        end else if (rf.start) begin
            run_d = 1'b1;
            cnt_d = '0;
            sc_d  = '0;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= '0;
            sc_q  <= '0;
            run_q <= 1'b0;
            ts_q  <= 1'b0;
            tl_q  <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            sc_q  <= sc_d;
            run_q <= run_d;
            ts_q  <= ts_d;
            tl_q  <= tl_d;
        end
    end

    assign rf.tap_short = ts_q;
    assign rf.tap_long  = tl_q;
    assign rf.running   = run_q;
endmodule

// file: core/lsfd_core.sv
// Module: six-channel low-side fault diagnostics and protection
// Notes on behaviour
// - Diagnostics run only while both enables high
// - Shorts checked on, open/ground checked off
// - On faults cut gate; off faults only report
// - Two-bit fault code per channel, read together
// - Blanking timer on each command edge
// - Filter timer on threshold crossing when stable
// - Enable rise restarts all blanking timers
// - Per-channel timers, shared durations
// - Short threshold select per three-channel group
// - Short fault when above threshold at expiry
// - Per-channel mode bit: latch-off or retry
// - Latch-off holds gate off until re-toggled
// - Auto-retry: off for refresh, then retry
// - Refresh tap chosen per channel group
// - Global refresh timer, 10 ms and 40 ms
// - First fault gets full refresh period
// - Off channel checked at off-blank or filter end
// - Off classes: none, ground short, open load
// - Status flag compares open-load threshold
// - Status flag is OR of unmasked channels
// - Captured code held until a valid frame
// - No capture while a timer runs
// - Gate needs reset, enables, no short, command
`timescale 1ns/1ps
module lsfd_core
    import lsfd_pkg::*;
#(
    parameter int ON_BLANK_CYC  = ON_BLANK_CYC_DEF,
    parameter int OFF_BLANK_CYC = OFF_BLANK_CYC_DEF,
    parameter int FILTER_CYC    = FILTER_CYC_DEF,
    parameter int SHORT_CYC     = REFRESH_SHORT_CYC,
    parameter int LONG_CYC      = REFRESH_LONG_CYC
) (
    // Clock and reset
    input  wire logic                clk_sys,
    input  wire logic                resetn,
    // Enables and commands
    input  wire logic                primary_enable,
    input  wire logic                output_enable,
    input  wire logic [NCH-1:0]      parallel_command,
    input  wire logic [NCH-1:0]      serial_gate_bit,
    // Configuration
    input  wire logic [NCH-1:0]      disable_mode_bit,
    input  wire logic                refresh_select_low_group,
    input  wire logic                refresh_select_high_group,
    input  wire logic [1:0]          threshold_select_low_group,
    input  wire logic [1:0]          threshold_select_high_group,
    input  wire logic [NCH-1:0]      flag_mask_clear,
    // Comparator results per channel
    input  wire logic [NCH-1:0]      drain_above_open,
    input  wire logic [NCH-1:0]      drain_below_ground,
    input  wire logic [4*NCH-1:0]    drain_above_short_step,
    // Frame handshake
    input  wire logic                frame_valid_done,
    // Outputs
    output logic [NCH-1:0]           gate_drive,
    output logic [2*NCH-1:0]         fault_code_bits,
    output logic [NCH-1:0]           shorted_load_state,
    output logic                     bias_enable,
    output logic                     fault_flag_n_oe_n,
    output logic                     drain_status_flag_n_oe_n
);
    lsfd_refresh_if rf ();

    lsfd_refresh_timer #(
        .SHORT_CYC (SHORT_CYC),
        .LONG_CYC  (LONG_CYC)
    ) u_refresh (
        .clk_sys   (clk_sys),
        .resetn    (resetn),
        .rf        (rf)
    );

    // ------------------------------------------------------------
    // Threshold decode
    // ------------------------------------------------------------
    function automatic logic above_step(input logic [3:0] steps,
                                        input logic [1:0] sel);
        above_step = steps[sel];
    endfunction

    logic diag_en;
    logic both_q, both_d;
    logic en_rise;
    logic [NCH-1:0] cmd;

    assign diag_en = primary_enable && output_enable;
    assign en_rise = diag_en && !both_q;
    assign cmd     = parallel_command | serial_gate_bit;

    // ------------------------------------------------------------
    // Per-channel state
    // ------------------------------------------------------------
    lsfd_tmr_t        st_q [NCH];
    lsfd_tmr_t        st_d [NCH];
    logic [TMR_W-1:0] tc_q [NCH];
    logic [TMR_W-1:0] tc_d [NCH];
    logic [NCH-1:0]   cmd_q, cmd_d;
    logic [NCH-1:0]   on_q, on_d;
    logic [NCH-1:0]   cmpst_q, cmpst_d;
    logic [NCH-1:0]   shrt_q, shrt_d;
    logic [NCH-1:0]   lock_q, lock_d;
    logic [NCH-1:0]   wait_q, wait_d;
    logic [NCH-1:0]   seen_q, seen_d;
    logic [NCH-1:0]   cap_q, cap_d;
    logic [1:0]       code_q [NCH];
    logic [1:0]       code_d [NCH];
    logic [NCH-1:0]   gate_q, gate_d;
    logic             flt_q, flt_d;
    logic             sta_q, sta_d;
    logic             bias_q, bias_d;
    logic             oe_q;
    logic [NCH-1:0]   short_cmp, off_cmp, tap, expire, start_req;

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            // Group threshold and refresh tap select
            assign short_cmp[g] = above_step(
                drain_above_short_step[4*g +: 4],
                (g < 3) ? threshold_select_low_group
                        : threshold_select_high_group);
            assign off_cmp[g] = !drain_above_open[g];
            assign tap[g] = ((g < 3) ? refresh_select_low_group
                                     : refresh_select_high_group)
                            ? rf.tap_long : rf.tap_short;
            assign expire[g] = (st_q[g] != LSFD_IDLE) &&
                               (tc_q[g] == '0);

            always_comb begin
                logic       cur_cmp;
                logic [1:0] cls;
                cur_cmp = on_q[g] ? short_cmp[g] : off_cmp[g];
                st_d[g]    = st_q[g];
                tc_d[g]    = tc_q[g];
                cmd_d[g]   = cmd[g];
                on_d[g]    = on_q[g];
                cmpst_d[g] = cur_cmp;
                shrt_d[g]  = shrt_q[g];
                lock_d[g]  = lock_q[g];
                wait_d[g]  = wait_q[g];
                seen_d[g]  = seen_q[g];
                cap_d[g]   = cap_q[g];
                code_d[g]  = code_q[g];
                start_req[g] = 1'b0;
                cls = FC_NONE;
                if (!on_q[g]) begin
                    if (drain_below_ground[g]) begin
                        cls = FC_GND;
                    end else if (!drain_above_open[g]) begin
                        cls = FC_OPEN;
                    end
                end else if (short_cmp[g]) begin
                    cls = FC_SHORT;
                end
                // Latch-off release on command low or output disable
                if (lock_q[g] && (!cmd[g] || !output_enable)) begin
                    lock_d[g] = 1'b0;
                    shrt_d[g] = 1'b0;
                end
                // Auto-retry end of refresh period
                if (wait_q[g] && tap[g]) begin
                    wait_d[g] = 1'b0;
                    shrt_d[g] = 1'b0;
                end
                if (frame_valid_done) begin
                    cap_d[g]  = 1'b0;
                    code_d[g] = FC_NONE;
                end
                if (!diag_en) begin
                    st_d[g]   = LSFD_IDLE;
                    tc_d[g]   = '0;
                    on_d[g]   = 1'b0;
                    wait_d[g] = 1'b0;
                    shrt_d[g] = lock_q[g] && output_enable;
                end else if (en_rise || (gate_d[g] != on_q[g])) begin
                    // Fresh command state or enable rise
                    on_d[g] = gate_d[g];
                    st_d[g] = LSFD_BLANK;
                    tc_d[g] = gate_d[g] ? TMR_W'(ON_BLANK_CYC - 1)
                                        : TMR_W'(OFF_BLANK_CYC - 1);
                end else if (st_q[g] != LSFD_IDLE && tc_q[g] != '0) begin
                    tc_d[g] = tc_q[g] - 1'b1;
                end else if (expire[g]) begin
                    st_d[g] = LSFD_IDLE;
                    if (cls != FC_NONE && !cap_d[g]) begin
                        cap_d[g]  = 1'b1;
                        code_d[g] = cls;
                    end
                    if (cls == FC_SHORT) begin
                        shrt_d[g] = 1'b1;
                        if (disable_mode_bit[g]) begin
                            lock_d[g] = 1'b1;
                        end else begin
                            wait_d[g] = 1'b1;
                            start_req[g] = 1'b1;
                        end
                    end
                end else if (cur_cmp != cmpst_q[g]) begin
                    st_d[g] = LSFD_FILT;
                    tc_d[g] = TMR_W'(FILTER_CYC - 1);
                end
            end

            always_comb begin
                gate_d[g] = resetn && diag_en && !shrt_q[g] &&
                            cmd[g];
            end
        end
    endgenerate

    assign rf.start = |start_req | (|wait_q);

    // ------------------------------------------------------------
    // Flags
    // ------------------------------------------------------------
    always_comb begin
        both_d = diag_en;
        bias_d = diag_en;
        sta_d  = !(primary_enable &&
                 |(flag_mask_clear & ~drain_above_open));
        flt_d  = !(primary_enable && |(flag_mask_clear & cap_q));
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            both_q  <= 1'b0;
            cmd_q   <= '0;
            on_q    <= '0;
            cmpst_q <= '0;
            shrt_q  <= '0;
            lock_q  <= '0;
            wait_q  <= '0;
            seen_q  <= '0;
            cap_q   <= '0;
            gate_q  <= '0;
            flt_q   <= 1'b1;
            sta_q   <= 1'b1;
            bias_q  <= 1'b0;
            oe_q    <= 1'b0;
            for (int i = 0; i < NCH; i++) begin
                st_q[i]   <= LSFD_IDLE;
                tc_q[i]   <= '0;
                code_q[i] <= FC_NONE;
            end
        end else begin
            both_q  <= both_d;
            cmd_q   <= cmd_d;
            on_q    <= on_d;
            cmpst_q <= cmpst_d;
            shrt_q  <= shrt_d;
            lock_q  <= lock_d;
            wait_q  <= wait_d;
            seen_q  <= seen_d;
            cap_q   <= cap_d;
            gate_q  <= gate_d;
            flt_q   <= flt_d;
            sta_q   <= sta_d;
            bias_q  <= bias_d;
            oe_q    <= output_enable;
            for (int i = 0; i < NCH; i++) begin
                st_q[i]   <= st_d[i];
                tc_q[i]   <= tc_d[i];
                code_q[i] <= code_d[i];
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_comb begin
        gate_drive               = gate_q;
        shorted_load_state       = shrt_q;
        bias_enable              = bias_q;
        fault_flag_n_oe_n        = flt_q;
        drain_status_flag_n_oe_n = sta_q;
        for (int i = 0; i < NCH; i++) begin
            fault_code_bits[2*i +: 2] = code_q[i];
        end
    end
endmodule

// file: dv/lsfd_checker.sv
// Checker: port-level assertions for the fault diagnostics block
`timescale 1ns/1ps
module lsfd_checker (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        resetn,
    // Inputs
    input wire logic        primary_enable,
    input wire logic        output_enable,
    input wire logic [5:0]  parallel_command,
    input wire logic [5:0]  serial_gate_bit,
    input wire logic [5:0]  disable_mode_bit,
    input wire logic [5:0]  flag_mask_clear,
    input wire logic [5:0]  drain_above_open,
    input wire logic        frame_valid_done,
    // Outputs
    input wire logic [5:0]  gate_drive,
    input wire logic [11:0] fault_code_bits,
    input wire logic [5:0]  shorted_load_state,
    input wire logic        bias_enable,
    input wire logic        fault_flag_n_oe_n,
    input wire logic        drain_status_flag_n_oe_n
);
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    sequence short_hit;
        $rose(shorted_load_state[0]) && !disable_mode_bit[0];
    endsequence
    chk_gate_enables: assert property (
        gate_drive != 6'h00 |-> $past(primary_enable && output_enable))
        else $error("gate on while disabled");
    chk_gate_command: assert property (
        (gate_drive & ~$past(parallel_command | serial_gate_bit)) == 6'h00)
        else $error("gate on without command");
    chk_gate_short: assert property (
        (gate_drive & $past(shorted_load_state)) == 6'h00)
        else $error("gate on during short");
    chk_bias_follow: assert property (
        $past(resetn) |-> bias_enable == $past(primary_enable && output_enable))
        else $error("bias enable wrong");
    chk_flag_primary: assert property (
        !primary_enable |=> fault_flag_n_oe_n && drain_status_flag_n_oe_n)
        else $error("flag active with primary enable low");
    chk_status_flag: assert property (
        $past(resetn) |-> drain_status_flag_n_oe_n == !($past(primary_enable)
        && |($past(flag_mask_clear & ~drain_above_open))))
        else $error("status flag wrong");
    chk_code_hold: assert property (
        $past(resetn) && $past(primary_enable) && !$past(frame_valid_done)
        && $past(fault_code_bits[1:0]) != 2'h0
        |-> $stable(fault_code_bits[1:0]))
        else $error("captured code changed");
    chk_retry_wait: assert property (
        short_hit |=> !gate_drive[0] [*8])
        else $error("retry too early");
endmodule
bind lsfd_core lsfd_checker u_chk (.clk_sys, .resetn, .primary_enable,
    .output_enable, .parallel_command, .serial_gate_bit, .disable_mode_bit,
    .flag_mask_clear, .drain_above_open, .frame_valid_done, .gate_drive,
    .fault_code_bits, .shorted_load_state, .bias_enable, .fault_flag_n_oe_n,
    .drain_status_flag_n_oe_n);

// file: dv/lsfd_host_model.sv
// Partner: host side reading flags and fault frames
`timescale 1ns/1ps
module lsfd_host_model (
    // Clock
    input wire logic        clk_sys,
    // Device pins
    input wire logic        fault_oe_n,
    input wire logic        status_oe_n,
    input wire logic [11:0] fault_code_bits,
    output logic            fault_pin,
    output logic            status_pin,
    // Frame control
    input wire logic        frame_req,
    output logic            frame_valid_done,
    output logic [11:0]     read_data
);
    // ------------------------------------------------------------
    // Pull-ups and frame capture
    // ------------------------------------------------------------
    assign fault_pin  = fault_oe_n ? 1'b1 : 1'b0;
    assign status_pin = status_oe_n ? 1'b1 : 1'b0;
    initial frame_valid_done = 1'b0;
    initial read_data = 12'h000;
    always @(posedge clk_sys) begin
        frame_valid_done <= frame_req;
        if (frame_req) read_data <= fault_code_bits;
    end
endmodule

// file: dv/test_lsfd_core.sv
// Testbench: scenarios for the fault diagnostics block
`timescale 1ns/1ps
module test_lsfd_core;
    import lsfd_pkg::*;
    localparam int OB = 20;
    localparam int FT = 10;
    localparam int SC = 200;
    localparam int LC = 800;
    logic        clk_sys, resetn, pe, oe, rs_lo, rs_hi, fv, frame_req;
    logic        bias, f_oe, s_oe, fault_pin, status_pin;
    logic [5:0]  cmd, sgb, mode, mask, above, below, gate, shrt;
    logic [1:0]  thr_lo, thr_hi;
    logic [23:0] step;
    logic [11:0] code, rd;
    int          error_cnt, total_checks, n;
    // ------------------------------------------------------------
    // Design and host
    // ------------------------------------------------------------
    lsfd_core #(.ON_BLANK_CYC(OB), .OFF_BLANK_CYC(OB), .FILTER_CYC(FT),
        .SHORT_CYC(SC), .LONG_CYC(LC)) dut (
        .clk_sys, .resetn, .primary_enable(pe), .output_enable(oe),
        .parallel_command(cmd), .serial_gate_bit(sgb),
        .disable_mode_bit(mode), .refresh_select_low_group(rs_lo),
        .refresh_select_high_group(rs_hi), .threshold_select_low_group(thr_lo),
        .threshold_select_high_group(thr_hi), .flag_mask_clear(mask),
        .drain_above_open(above), .drain_below_ground(below),
        .drain_above_short_step(step), .frame_valid_done(fv),
        .gate_drive(gate), .fault_code_bits(code), .shorted_load_state(shrt),
        .bias_enable(bias), .fault_flag_n_oe_n(f_oe),
        .drain_status_flag_n_oe_n(s_oe));
    lsfd_host_model host (.clk_sys, .fault_oe_n(f_oe), .status_oe_n(s_oe),
        .fault_code_bits(code), .fault_pin, .status_pin, .frame_req,
        .frame_valid_done(fv), .read_data(rd));
    always #10 clk_sys = ~clk_sys;
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(string nm, logic [11:0] seen, logic [11:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic cyc(int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask
    task automatic frame();
        cyc(1);
        frame_req = 1'b1;
        cyc(1);
        frame_req = 1'b0;
        cyc(2);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        error_cnt++;
        tally_and_finish();
    end
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        {clk_sys, resetn, rs_lo, rs_hi, frame_req} = 5'h00;
        {pe, oe, thr_lo, thr_hi, cmd, sgb, mode, below} = 30'h30000000;
        {mask, above, step} = 36'hFFF000000;
        error_cnt = 0;
        total_checks = 0;
        cyc(20);
        chk("reset gate", 12'(gate), 12'h000);
        chk("reset code", code, 12'h000);
        chk("reset oe_n", 12'({f_oe, s_oe}), 12'h003);
        resetn = 1'b1;
        cyc(3);
        $display("test reset done");
        above = 6'h3C;
        below = 6'h01;
        pe = 1'b0;
        cyc(3);
        pe = 1'b1;
        cyc(OB + 5);
        chk("off codes", code, {8'h00, FC_OPEN, FC_GND});
        chk("off gate", 12'(gate), 12'h000);
        chk("fault pin", 12'(fault_pin), 12'h000);
        chk("status pin", 12'(status_pin), 12'h000);
        mask = 6'h3C;
        cyc(3);
        chk("status masked", 12'(status_pin), 12'h001);
        mask = 6'h3F;
        above = 6'h3F;
        below = 6'h00;
        cyc(FT + 5);
        chk("held code", code, {8'h00, FC_OPEN, FC_GND});
        frame();
        chk("read data", rd, {8'h00, FC_OPEN, FC_GND});
        chk("cleared code", code, 12'h000);
        $display("test off faults done");
        thr_lo = 2'h1;
        thr_hi = 2'h2;
        step = 24'h003003;
        cmd = 6'h09;
        cyc(2);
        chk("gate on", 12'(gate), 12'h009);
        cyc(OB + 3);
        chk("short code", code, {10'h000, FC_SHORT});
        chk("short gate", 12'(gate), 12'h008);
        chk("short state", 12'(shrt), 12'h001);
        n = 0;
        while (gate[0] !== 1'b1 && n < SC + 50) begin
            cyc(1);
            n++;
        end
        chk("retry delay", 12'(n >= SC - 10 && n <= SC + 2), 12'h001);
        cyc(OB + 5);
        chk("retry refault", 12'(gate), 12'h008);
        cmd = 6'h00;
        step = 24'h000000;
        cyc(OB + 5);
        frame();
        chk("short cleared", code, 12'h000);
        $display("test auto retry done");
        mode = 6'h02;
        step = 24'h000030;
        sgb = 6'h02;
        cyc(OB + 5);
        chk("latch code", code, {8'h00, FC_SHORT, 2'h0});
        cyc(SC + 20);
        chk("latch stays off", 12'(gate), 12'h000);
        sgb = 6'h00;
        cyc(3);
        sgb = 6'h02;
        cyc(2);
        chk("latch toggle", 12'(gate), 12'h002);
        oe = 1'b0;
        cyc(2);
        chk("oe low gate", 12'(gate), 12'h000);
        chk("oe low bias", 12'(bias), 12'h000);
        oe = 1'b1;
        cyc(2);
        chk("oe toggle", 12'(gate), 12'h002);
        $display("test latch off done");
        tally_and_finish();
    end
endmodule
